// [hw/dtc_timer.sv]
`timescale 1ns/100ps
// Contract
// - Two independent 16-bit timer/counters, 0 and 1, timer or event counter.
// - Timer operation counts once per machine cycle of twelve clocks.
// - Counter operation counts falling edges on that timer's count input.
// - Edge recognition takes two machine cycles; max rate one twenty-fourth of the clock.
// - Control bit 6 starts timer 1, bit 4 starts timer 0.
// - Two-bit mode: 00 13-bit, 01 16-bit, 10 reload, 11 special.
// - 13-bit mode uses low five bits of low byte and high byte.
// - 13-bit mode zeroes the low byte's upper three bits on every count step.
// - Reload mode counts low byte; on overflow loads it from high byte.
// - Timer 1 in mode 11 stops counting.
// - Timer 0 in mode 11 becomes two independent 8-bit counters.
// - Split low byte uses timer 0 controls; high byte uses run bit one.
// - Counter-select bit 1 counts events, 0 counts machine cycles.
// - Overflow sets flag; software or interrupt service clears it.
// - Clearing a run bit halts the timer, count unchanged.
module dtc_timer (
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic       sfr_wr_in,
   input  wire logic [7:0] sfr_addr_in,
   input  wire logic [7:0] sfr_wdata_in,
   output logic      [7:0] sfr_rdata_out,
   input  wire logic       count_input_zero_in,
   input  wire logic       count_input_one_in,
   input  wire logic       gate_pin_zero_in,
   input  wire logic       gate_pin_one_in,
   input  wire logic       irq_ack_zero_in,
   input  wire logic       irq_ack_one_in,
   output logic            overflow_flag_zero_out,
   output logic            overflow_flag_one_out
);

   dtc_pkg::dtc_wreq_t wreq;
   assign wreq = '{wr: sfr_wr_in, addr: sfr_addr_in, data: sfr_wdata_in};

   logic [7:0] control_ff;
   logic [7:0] mode_ff;
   logic [7:0] count_low_zero_ff;
   logic [7:0] count_low_one_ff;
   logic [7:0] count_high_zero_ff;
   logic [7:0] count_high_one_ff;
   logic [7:0] rdata_ff;

   // Machine cycle prescaler.
   logic [dtc_pkg::MC_CW-1:0] presc_ff;
   logic                      mc_tick;
   assign mc_tick = (presc_ff == dtc_pkg::MC_CW'(dtc_pkg::MC_CLOCKS - 1));

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         presc_ff <= '0;
      end else if (mc_tick) begin
         presc_ff <= '0;
      end else begin
         presc_ff <= presc_ff + 1'b1;
      end
   end

   // Pins cross into the clock domain through two flops, then count pins are
   // sampled once per machine cycle; a fall seen across two samples is an event.
   // The slow sampling is what needs the source to hold each level.
   logic [3:0] pin_raw;
   logic [3:0] sync1_ff;
   logic [3:0] sync2_ff;
   logic [1:0] samp_ff;
   logic [1:0] samp_old_ff;
   logic [1:0] fall_ff;
   assign pin_raw = {gate_pin_one_in, gate_pin_zero_in,
                     count_input_one_in, count_input_zero_in};

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_ff    <= '0;
         sync2_ff    <= '0;
         samp_ff     <= '0;
         samp_old_ff <= '0;
         fall_ff     <= '0;
      end else begin
         sync1_ff <= pin_raw;
         sync2_ff <= sync1_ff;
         if (mc_tick) begin
            samp_ff     <= sync2_ff[1:0];
            samp_old_ff <= samp_ff;
            fall_ff     <= samp_old_ff & ~samp_ff;
         end else begin
            fall_ff <= '0;
         end
      end
   end

   function automatic dtc_pkg::dtc_cfg_t decode_cfg(input logic [3:0] nib);
      decode_cfg.gate    = nib[dtc_pkg::MOD_GATE];
      decode_cfg.counter = nib[dtc_pkg::MOD_COUNTER];
      decode_cfg.mode    = dtc_pkg::dtc_mode_t'(
         {nib[dtc_pkg::MOD_HI], nib[dtc_pkg::MOD_LO]});
   endfunction

   dtc_pkg::dtc_cfg_t cfg0;
   dtc_pkg::dtc_cfg_t cfg1;
   assign cfg0 = decode_cfg(mode_ff[3:0]);
   assign cfg1 = decode_cfg(mode_ff[dtc_pkg::MOD_NIBBLE1 +: 4]);

   logic run0;
   logic run1;
   assign run0 = control_ff[dtc_pkg::CTL_RUN0];
   assign run1 = control_ff[dtc_pkg::CTL_RUN1];

   // Gate high means the gating pin must also be high to count.
   logic en0;
   logic en1;
   assign en0 = run0 & (~cfg0.gate | sync2_ff[2]);
   assign en1 = run1 & (~cfg1.gate | sync2_ff[3]);

   logic inc0;
   logic inc1;
   logic inc0h;
   assign inc0 = en0 & (cfg0.counter ? fall_ff[0] : mc_tick);
   assign inc1 = en1 & (cfg1.counter ? fall_ff[1] : mc_tick)
                 & (cfg1.mode != dtc_pkg::DTC_MODE_SPLIT);
   // Split high byte always times machine cycles under run bit one.
   assign inc0h = run1 & mc_tick;

   logic split0;
   assign split0 = (cfg0.mode == dtc_pkg::DTC_MODE_SPLIT);

   // Next count values for one timer.
   function automatic logic [16:0] step(input dtc_pkg::dtc_mode_t m,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
      logic [13:0] s13;
      logic [16:0] s16;
      logic [8:0]  s8;
      s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h0_0001;
      s8  = {1'b0, lo} + 9'h001;
      case (m)
         dtc_pkg::DTC_MODE_13BIT: begin
            step = {s13[13], s13[12:5], 3'b000, s13[4:0]};
         end
         dtc_pkg::DTC_MODE_16BIT: begin
            step = s16;
         end
         dtc_pkg::DTC_MODE_RELOAD: begin
            step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
         end
         default: begin
            step = {s8[8], hi, s8[7:0]};
         end
      endcase
   endfunction

   logic [16:0] st0;
   logic [16:0] st1;
   logic [8:0]  st0h;
   assign st0  = step(cfg0.mode, count_low_zero_ff, count_high_zero_ff);
   assign st1  = step(cfg1.mode, count_low_one_ff, count_high_one_ff);
   assign st0h = {1'b0, count_high_zero_ff} + 9'h001;

   logic ovf0;
   logic ovf1;
   logic ovf0h;
   assign ovf0  = inc0 & st0[16];
   assign ovf0h = split0 & inc0h & st0h[8];
   assign ovf1  = inc1 & st1[16];

   logic wr_ctl;
   logic wr_mod;
   logic wr_l0;
   logic wr_l1;
   logic wr_h0;
   logic wr_h1;
   assign wr_ctl = wreq.wr & (wreq.addr == dtc_pkg::ADDR_CONTROL);
   assign wr_mod = wreq.wr & (wreq.addr == dtc_pkg::ADDR_MODE);
   assign wr_l0  = wreq.wr & (wreq.addr == dtc_pkg::ADDR_LOW0);
   assign wr_l1  = wreq.wr & (wreq.addr == dtc_pkg::ADDR_LOW1);
   assign wr_h0  = wreq.wr & (wreq.addr == dtc_pkg::ADDR_HIGH0);
   assign wr_h1  = wreq.wr & (wreq.addr == dtc_pkg::ADDR_HIGH1);

   // Flags: set wins over a software clear or an interrupt acknowledge.
   logic [7:0] nxt_control;
   assign nxt_control = {
      ovf1 | ovf0h | ((wr_ctl ? wreq.data[dtc_pkg::CTL_OVF1]
                               : control_ff[dtc_pkg::CTL_OVF1])
                      & ~irq_ack_one_in),
      wr_ctl ? wreq.data[dtc_pkg::CTL_RUN1] : run1,
      ovf0 | ((wr_ctl ? wreq.data[dtc_pkg::CTL_OVF0]
                      : control_ff[dtc_pkg::CTL_OVF0])
              & ~irq_ack_zero_in),
      wr_ctl ? wreq.data[dtc_pkg::CTL_RUN0] : run0,
      wr_ctl ? wreq.data[3:0] : control_ff[3:0]
   };

   // Counts: a software write takes precedence over a count step.
   logic [7:0] nxt_l0;
   logic [7:0] nxt_h0;
   logic [7:0] nxt_l1;
   logic [7:0] nxt_h1;
   assign nxt_l0 = wr_l0 ? wreq.data :
                   inc0 ? st0[7:0] : count_low_zero_ff;
   assign nxt_h0 = wr_h0 ? wreq.data :
                   split0 ? (inc0h ? st0h[7:0] : count_high_zero_ff) :
                   inc0 ? st0[15:8] : count_high_zero_ff;
   assign nxt_l1 = wr_l1 ? wreq.data :
                   inc1 ? st1[7:0] : count_low_one_ff;
   assign nxt_h1 = wr_h1 ? wreq.data :
                   inc1 ? st1[15:8] : count_high_one_ff;

   logic [7:0] rd_mux;
   assign rd_mux =
      (sfr_addr_in == dtc_pkg::ADDR_CONTROL) ? control_ff :
      (sfr_addr_in == dtc_pkg::ADDR_MODE)    ? mode_ff :
      (sfr_addr_in == dtc_pkg::ADDR_LOW0)    ? count_low_zero_ff :
      (sfr_addr_in == dtc_pkg::ADDR_LOW1)    ? count_low_one_ff :
      (sfr_addr_in == dtc_pkg::ADDR_HIGH0)   ? count_high_zero_ff :
      (sfr_addr_in == dtc_pkg::ADDR_HIGH1)   ? count_high_one_ff : 8'h00;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         control_ff         <= dtc_pkg::RST_CONTROL;
         mode_ff            <= dtc_pkg::RST_MODE;
         count_low_zero_ff  <= dtc_pkg::RST_COUNT;
         count_low_one_ff   <= dtc_pkg::RST_COUNT;
         count_high_zero_ff <= dtc_pkg::RST_COUNT;
         count_high_one_ff  <= dtc_pkg::RST_COUNT;
         rdata_ff           <= 8'h00;
      end else begin
         control_ff         <= nxt_control;
         mode_ff            <= wr_mod ? wreq.data : mode_ff;
         count_low_zero_ff  <= nxt_l0;
         count_low_one_ff   <= nxt_l1;
         count_high_zero_ff <= nxt_h0;
         count_high_one_ff  <= nxt_h1;
         rdata_ff           <= rd_mux;
      end
   end

   assign sfr_rdata_out          = rdata_ff;
   assign overflow_flag_zero_out = control_ff[dtc_pkg::CTL_OVF0];
   assign overflow_flag_one_out  = control_ff[dtc_pkg::CTL_OVF1];

endmodule

// [hw/dtc_pkg.sv]
package dtc_pkg;

   // Register addresses on the special function register port.
   localparam logic [7:0] ADDR_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_MODE    = 8'h89;
   localparam logic [7:0] ADDR_LOW0    = 8'h8a;
   localparam logic [7:0] ADDR_LOW1    = 8'h8b;
   localparam logic [7:0] ADDR_HIGH0   = 8'h8c;
   localparam logic [7:0] ADDR_HIGH1   = 8'h8d;

   // Field positions in the control register.
   localparam int CTL_OVF1 = 7;
   localparam int CTL_RUN1 = 6;
   localparam int CTL_OVF0 = 5;
   localparam int CTL_RUN0 = 4;

   // Field positions in the mode select register, per timer nibble.
   localparam int MOD_GATE    = 3;
   localparam int MOD_COUNTER = 2;
   localparam int MOD_HI      = 1;
   localparam int MOD_LO      = 0;
   localparam int MOD_NIBBLE1 = 4;

   // Reset values.
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_MODE    = 8'h00;
   localparam logic [7:0] RST_COUNT   = 8'h00;

   // Timing: one machine cycle is twelve processor clocks.
   localparam int MC_CLOCKS = 12;
   localparam int MC_CW     = 4;

   typedef enum logic [1:0] {
      DTC_MODE_13BIT,
      DTC_MODE_16BIT,
      DTC_MODE_RELOAD,
      DTC_MODE_SPLIT
   } dtc_mode_t;

   // Register write request.
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } dtc_wreq_t;

   // Per timer configuration decoded from one mode nibble.
   typedef struct packed {
      logic      gate;
      logic      counter;
      dtc_mode_t mode;
   } dtc_cfg_t;

endpackage

// [verif/dtc_pulse_src.sv]
`timescale 1ns/100ps
// Drives a count pin that idles high and toggles every HALF clocks.
module dtc_pulse_src #(
   parameter int HALF = 12
) (
   input  wire logic clk_in,
   input  wire logic go_in,
   output logic      pin_out
);
   logic [7:0] ph_ff;
   always_ff @(posedge clk_in) begin
      if (!go_in) begin
         ph_ff <= 8'h00;
         pin_out <= 1'b1;
      end else if (ph_ff == 8'(HALF - 1)) begin
         ph_ff <= 8'h00;
         pin_out <= ~pin_out;
      end else begin
         ph_ff <= ph_ff + 8'h01;
      end
   end
endmodule

// [verif/dtc_timer_monitor.sv]
`timescale 1ns/100ps
module dtc_timer_monitor (
   input wire logic       clk_in,
   input wire logic       nrst_in,
   input wire logic       sfr_wr_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic       irq_ack_zero_in,
   input wire logic       irq_ack_one_in,
   input wire logic       overflow_flag_zero_out,
   input wire logic       overflow_flag_one_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   logic      [7:0] mode_ff, ctl_ff, stab_ff;
   wire logic [7:0] ad = sfr_addr_in;
   wire logic [7:0] rd = sfr_rdata_out;
   wire logic       wctl = sfr_wr_in && ad == dtc_pkg::ADDR_CONTROL;
   wire logic       lo0 = ad == dtc_pkg::ADDR_LOW0 && !sfr_wr_in;
   wire logic       lo1 = ad == dtc_pkg::ADDR_LOW1 && !sfr_wr_in;
   wire logic       run0 = ctl_ff[dtc_pkg::CTL_RUN0];
   wire logic       stop1 = !ctl_ff[dtc_pkg::CTL_RUN1] || mode_ff[5:4] == 2'h3;
   wire logic       cond = lo0 && run0 && mode_ff[3:0] == 4'h1;
   // The stable-run counter is armed only after a first step is seen, so
   // the unknown prescaler phase at start cannot trip it.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_ff <= 8'h00;
         ctl_ff <= 8'h00;
         stab_ff <= 8'hff;
      end else begin
         if (sfr_wr_in && ad == dtc_pkg::ADDR_MODE)
            mode_ff <= sfr_wdata_in;
         if (wctl)
            ctl_ff <= sfr_wdata_in;
         if (!(cond && $past(cond)))
            stab_ff <= 8'hff;
         else if ($changed(rd))
            stab_ff <= 8'h00;
         else if (stab_ff != 8'hff)
            stab_ff <= stab_ff + 8'h01;
      end
   end
   sequence s_mode_wr;
      sfr_wr_in && ad == dtc_pkg::ADDR_MODE;
   endsequence
   a_mode_read_back: assert property (
      s_mode_wr ##1 ad == dtc_pkg::ADDR_MODE
      |=> rd == $past(sfr_wdata_in, 2))
      else $error("mode register read back differs");
   a_unmapped_zero: assert property (
      (ad < dtc_pkg::ADDR_CONTROL || ad > dtc_pkg::ADDR_HIGH1) |=> rd == 8'h00)
      else $error("unmapped address read not zero");
   a_halt_timer_zero: assert property (
      (lo0 && !run0) ##1 lo0 |=> $stable(rd))
      else $error("stopped timer zero count moved");
   a_mode3_stops_one: assert property (
      (lo1 && stop1) ##1 lo1 |=> $stable(rd))
      else $error("stopped timer one count moved");
   a_flag_zero_holds: assert property (
      overflow_flag_zero_out && !wctl && !irq_ack_zero_in && !$past(wctl)
      && !$past(irq_ack_zero_in) |=> overflow_flag_zero_out)
      else $error("overflow flag zero dropped without cause");
   a_flag_one_holds: assert property (
      overflow_flag_one_out && !wctl && !irq_ack_one_in && !$past(wctl)
      && !$past(irq_ack_one_in) |=> overflow_flag_one_out)
      else $error("overflow flag one dropped without cause");
   a_step_by_one: assert property (
      cond && $past(cond) && $past(cond, 2) && $changed(rd)
      |-> rd == $past(rd) + 8'h01)
      else $error("timer step not one");
   a_tick_period: assert property (
      stab_ff <= 8'h0b || stab_ff == 8'hff)
      else $error("machine cycle tick too slow");
endmodule

// [verif/dtc_timer_tb.sv]
`timescale 1ns/100ps
module dtc_timer_tb;
   typedef struct packed {
      logic [7:0] m, lo, hi, n, elo, ehi, ef;
   } dtc_row_t;
   logic       clk_in, nrst_in, wr, go, ack1, pin1, f0, f1;
   logic [7:0] ad, wd, rdata;
   int         n_errors = 0;
   int         checked = 0;
   dtc_row_t   rows [6];
   dtc_timer dut_u (
      .clk_in(clk_in), .nrst_in(nrst_in), .sfr_wr_in(wr),
      .sfr_addr_in(ad), .sfr_wdata_in(wd), .sfr_rdata_out(rdata),
      .count_input_zero_in(1'b1), .count_input_one_in(pin1),
      .gate_pin_zero_in(1'b0), .gate_pin_one_in(1'b0),
      .irq_ack_zero_in(1'b0), .irq_ack_one_in(ack1),
      .overflow_flag_zero_out(f0), .overflow_flag_one_out(f1));
   dtc_pulse_src src_u (.clk_in(clk_in), .go_in(go), .pin_out(pin1));
   task automatic chk(input logic [7:0] got, exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrt(input logic [7:0] a, d);
      wr = 1'b1;
      ad = a;
      wd = d;
      @(negedge clk_in);
   endtask
   // The write strobe stays up until the next action lowers it, so that
   // two writes in a row never assign it twice in one time step.
   task automatic rdc(input logic [7:0] a, e);
      wr = 1'b0;
      ad = a;
      repeat (2) @(negedge clk_in);
      chk(rdata, e);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      #100000;
      n_errors++;
      close_out();
   end
   initial begin
      rows = '{56'h00_1e12_0301_1300, 56'h00_1fff_0201_0001,
               56'h00_fd00_011e_0000, 56'h01_fe34_0301_3500,
               56'h01_ffff_0201_0001, 56'h02_fea0_03a1_a001};
      {nrst_in, wr, go, ack1, ad, wd} = 20'h0_0000;
      repeat (5) @(negedge clk_in);
      nrst_in = 1'b1;
      // Timer one stays in reload with its run bit clear while timer zero runs each row.
      foreach (rows[i]) begin
         wrt(dtc_pkg::ADDR_CONTROL, 8'h00);
         wrt(dtc_pkg::ADDR_MODE, {6'h08, rows[i].m[1:0]});
         wrt(dtc_pkg::ADDR_LOW0, rows[i].lo);
         wrt(dtc_pkg::ADDR_HIGH0, rows[i].hi);
         wrt(dtc_pkg::ADDR_CONTROL, 8'h10);
         wr = 1'b0;
         ad = dtc_pkg::ADDR_LOW0;
         repeat (12 * rows[i].n - 1) @(negedge clk_in);
         // Closing the gate halts the count but keeps the flag for reading.
         wrt(dtc_pkg::ADDR_MODE, {6'h0a, rows[i].m[1:0]});
         chk({7'h00, f0}, rows[i].ef);
         wrt(dtc_pkg::ADDR_CONTROL, 8'h00);
         rdc(dtc_pkg::ADDR_LOW0, rows[i].elo);
         rdc(dtc_pkg::ADDR_HIGH0, rows[i].ehi);
      end
      wrt(dtc_pkg::ADDR_MODE, 8'h33);
      rdc(dtc_pkg::ADDR_MODE, 8'h33);
      wrt(dtc_pkg::ADDR_LOW0, 8'hff);
      wrt(dtc_pkg::ADDR_HIGH0, 8'hfe);
      wrt(dtc_pkg::ADDR_LOW1, 8'h05);
      wrt(dtc_pkg::ADDR_CONTROL, 8'h40);
      rdc(dtc_pkg::ADDR_LOW1, 8'h05);
      repeat (33) @(negedge clk_in);
      chk({6'h00, f1, f0}, 8'h02);
      wrt(dtc_pkg::ADDR_CONTROL, 8'h80);
      rdc(dtc_pkg::ADDR_HIGH0, 8'h01);
      rdc(dtc_pkg::ADDR_LOW0, 8'hff);
      ack1 = 1'b1;
      @(negedge clk_in);
      ack1 = 1'b0;
      repeat (2) @(negedge clk_in);
      chk({7'h00, f1}, 8'h00);
      wrt(dtc_pkg::ADDR_MODE, 8'h50);
      wrt(dtc_pkg::ADDR_LOW1, 8'h00);
      wrt(dtc_pkg::ADDR_CONTROL, 8'h40);
      wr = 1'b0;
      go = 1'b1;
      repeat (240) @(negedge clk_in);
      go = 1'b0;
      // Recognition lags the pin by up to three machine cycles.
      repeat (48) @(negedge clk_in);
      wrt(dtc_pkg::ADDR_CONTROL, 8'h00);
      rdc(dtc_pkg::ADDR_LOW1, 8'h0a);
      nrst_in = 1'b0;
      repeat (5) @(negedge clk_in);
      nrst_in = 1'b1;
      for (int a = 8'h88; a <= 8'h8d; a++)
         rdc(8'(a), 8'h00);
      wrt(8'h90, 8'h55);
      rdc(8'h90, 8'h00);
      close_out();
   end
endmodule
bind dtc_timer dtc_timer_monitor mon_u (
   .clk_in(clk_in), .nrst_in(nrst_in), .sfr_wr_in(sfr_wr_in),
   .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
   .sfr_rdata_out(sfr_rdata_out), .irq_ack_zero_in(irq_ack_zero_in),
   .irq_ack_one_in(irq_ack_one_in),
   .overflow_flag_zero_out(overflow_flag_zero_out),
   .overflow_flag_one_out(overflow_flag_one_out));
